// ===== design/wred_regs_pkg.sv
// package: register map, field layout and reset values of the port wred register bank
package wred_regs_pkg;
  // ==========================================================
  // register byte offsets within one port's register space
  localparam logic [11:0] OFF_PM_THR = 12'h830;
  localparam logic [11:0] OFF_PM_PROB = 12'h834;
  localparam logic [11:0] OFF_Q_THR = 12'h840;
  localparam logic [11:0] OFF_Q_PROB = 12'h844;
  localparam logic [11:0] OFF_Q_MON = 12'h848;
  localparam logic [11:0] OFF_TXQ_SEL = 12'h900;
  localparam logic [11:0] OFF_VID_REP = 12'h904;
  localparam logic [11:0] OFF_POLICE = 12'h80c;
  // ==========================================================
  // field positions
  localparam int HI_LSB = 16;
  localparam int HI_MSB = 26;
  localparam int LO_MSB = 10;
  localparam int BIT_RAND_EN = 31;
  localparam int BIT_FLUSH = 30;
  localparam int BIT_ALL_INH = 29;
  localparam int BIT_YR_INH = 28;
  localparam int BIT_R_INH = 27;
  localparam int BIT_DROP_ALL = 26;
  localparam int CNT_MSB = 23;
  // ==========================================================
  // reset values
  localparam logic [10:0] RST_PM_MAX = 11'h400;
  localparam logic [10:0] RST_PM_MIN = 11'h080;
  localparam logic [10:0] RST_PM_PROB = 11'h020;
  localparam logic [10:0] RST_Q_MAX = 11'h080;
  localparam logic [10:0] RST_Q_MIN = 11'h009;
  localparam logic [10:0] RST_Q_PROB = 11'h010;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  // ==========================================================
  // per-queue settings travel together
  typedef struct packed {
    logic [10:0] maxThr;
    logic [10:0] minThr;
    logic [10:0] probMult;
  } queue_cfg_t;
  // drop controls for the datapath
  typedef struct packed {
    logic randomDropEn;
    logic allColourDropInhibit;
    logic yellowRedDropInhibit;
    logic redDropInhibit;
    logic dropAll;
  } drop_ctrl_t;
endpackage

// ===== design/port_wred_queue_regs.sv
// port wred queue register bank with avalon-mm slave
`timescale 1ns/100ps
// Function
// - memory max/min thresholds, reset 0x400/0x080
// - memory probability multiplier, reset 0x020
// - memory average queue size read-only
// - queue fields follow selected queue index
// - queue max/min thresholds, reset 0x080/0x009
// - queue probability multiplier, reset 0x010
// - selected queue average size read-only
// - bit 31 enables random drop
// - rising edge of bit 30 clears counters
// - bit 29 inhibits all colour drops
// - bit 28 inhibits yellow and red drops
// - bit 27 inhibits red drops
// - bit 26 drops all above max
// - 24-bit read-only packet event counter
// - 2-bit queue index selects queue
// - vid replacement uses port default vid
// - with vid replacement on, double tagging replaces outer service tag
// - police enable gates wred operation
module port_wred_queue_regs #(
  parameter int NUM_QUEUES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [1:0] response,
  // averaging and event inputs from the datapath
  input wire logic [10:0] pmAvgSize,
  input wire logic [NUM_QUEUES*11-1:0] queueAvgSize,
  input wire logic [NUM_QUEUES-1:0] queueEvent,
  // configuration to the datapath
  output wred_regs_pkg::queue_cfg_t [NUM_QUEUES-1:0] queueCfg,
  output logic [10:0] pmMaxThr,
  output logic [10:0] pmMinThr,
  output logic [10:0] pmProbMult,
  output wred_regs_pkg::drop_ctrl_t dropCtrl,
  output logic wredActive,
  output logic vidReplaceEn,
  output logic outerServiceTagSel,
  // external control levels
  input wire logic doubleTagEn
);
  // ==========================================================
  // elaboration check
  if (NUM_QUEUES != 4) begin : gen_chk
    $error("queue index is two bits, NUM_QUEUES must be 4");
  end

  // ==========================================================
  // storage
  wred_regs_pkg::queue_cfg_t qCfg_ff [NUM_QUEUES]; // per-queue thresholds and multipliers
  logic [23:0] evCnt_ff [NUM_QUEUES]; // per-queue event counters
  logic [10:0] pmMax_ff, pmMin_ff, pmProb_ff; // packet-memory settings
  wred_regs_pkg::drop_ctrl_t drop_ff; // drop controls
  logic flushBit_ff; // stored flush bit, also edge reference
  logic [1:0] qSel_ff; // transmit queue index
  logic vidRep_ff; // vid replacement enable
  logic policeEn_ff; // police enable
  logic ack_ff; // answer phase flag
  logic [31:0] rdData_ff; // registered read data
  logic [1:0] resp_ff; // registered response
  logic [31:0] wMask; // byte mask from byteenable
  logic [31:0] wVal; // write data merged under mask into the current register word
  logic wrStb; // write accepted this edge
  logic flushEdge; // low to high on flush bit

  // ==========================================================
  // helpers
  // merges written bytes into an old word
  function automatic logic [31:0] merge(input logic [31:0] oldV, input logic [31:0] newV,
                                        input logic [31:0] m);
    merge = (oldV & ~m) | (newV & m);
  endfunction
  // packs two 11-bit fields into a word, reserved bits zero
  function automatic logic [31:0] pack2(input logic [10:0] hi, input logic [10:0] lo);
    pack2 = {5'h00, hi, 5'h00, lo};
  endfunction
  // decodes a known offset
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == wred_regs_pkg::OFF_PM_THR) || (a == wred_regs_pkg::OFF_PM_PROB) ||
             (a == wred_regs_pkg::OFF_Q_THR) || (a == wred_regs_pkg::OFF_Q_PROB) ||
             (a == wred_regs_pkg::OFF_Q_MON) || (a == wred_regs_pkg::OFF_TXQ_SEL) ||
             (a == wred_regs_pkg::OFF_VID_REP) || (a == wred_regs_pkg::OFF_POLICE);
  endfunction

  // ==========================================================
  // bus handshake: one wait cycle, answer on second edge
  assign wMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                  {8{byteenable[0]}}};
  assign wrStb = write && ack_ff;
  assign waitrequest = (read || write) && !ack_ff;
  assign readdata = rdData_ff;
  assign response = resp_ff;

  // answer phase toggles once per request
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (read || write) && !ack_ff;
    end
  end

  // current word of each register, reserved bits zero
  function automatic logic [31:0] regWord(input logic [11:0] a);
    regWord = 32'h00000000;
    case (a)
      wred_regs_pkg::OFF_PM_THR: regWord = pack2(pmMax_ff, pmMin_ff);
      wred_regs_pkg::OFF_PM_PROB: regWord = pack2(pmProb_ff, pmAvgSize);
      wred_regs_pkg::OFF_Q_THR: regWord = pack2(qCfg_ff[qSel_ff].maxThr,
                                                qCfg_ff[qSel_ff].minThr);
      wred_regs_pkg::OFF_Q_PROB: regWord = pack2(qCfg_ff[qSel_ff].probMult,
                                                 queueAvgSize[qSel_ff*11 +: 11]);
      wred_regs_pkg::OFF_Q_MON: regWord = {drop_ff.randomDropEn, flushBit_ff,
                                           drop_ff.allColourDropInhibit,
                                           drop_ff.yellowRedDropInhibit, drop_ff.redDropInhibit,
                                           drop_ff.dropAll, 2'h0, evCnt_ff[qSel_ff]};
      wred_regs_pkg::OFF_TXQ_SEL: regWord = {30'h00000000, qSel_ff};
      wred_regs_pkg::OFF_VID_REP: regWord = {31'h00000000, vidRep_ff};
      wred_regs_pkg::OFF_POLICE: regWord = {31'h00000000, policeEn_ff};
      default: regWord = 32'h00000000;
    endcase
  endfunction

  // masked new word for the addressed register
  assign wVal = merge(regWord(address), writedata, wMask);

  // read data and response captured at the first edge of a request, while ack_ff is low
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdData_ff <= 32'h00000000;
      resp_ff <= 2'h0;
    end else if ((read || write) && !ack_ff) begin
      rdData_ff <= read ? regWord(address) : 32'h00000000;
      resp_ff <= mapped(address) ? 2'h0 : 2'h2;
    end
  end

  // ==========================================================
  // packet-memory settings
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pmMax_ff <= wred_regs_pkg::RST_PM_MAX;
      pmMin_ff <= wred_regs_pkg::RST_PM_MIN;
      pmProb_ff <= wred_regs_pkg::RST_PM_PROB;
    end else if (wrStb && address == wred_regs_pkg::OFF_PM_THR) begin
      pmMax_ff <= wVal[wred_regs_pkg::HI_MSB:wred_regs_pkg::HI_LSB];
      pmMin_ff <= wVal[wred_regs_pkg::LO_MSB:0];
    end else if (wrStb && address == wred_regs_pkg::OFF_PM_PROB) begin
      pmProb_ff <= wVal[wred_regs_pkg::HI_MSB:wred_regs_pkg::HI_LSB];
    end
  end

  // per-queue settings, written only for the selected queue
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        qCfg_ff[i].maxThr <= wred_regs_pkg::RST_Q_MAX;
        qCfg_ff[i].minThr <= wred_regs_pkg::RST_Q_MIN;
        qCfg_ff[i].probMult <= wred_regs_pkg::RST_Q_PROB;
      end
    end else if (wrStb && address == wred_regs_pkg::OFF_Q_THR) begin
      qCfg_ff[qSel_ff].maxThr <= wVal[wred_regs_pkg::HI_MSB:wred_regs_pkg::HI_LSB];
      qCfg_ff[qSel_ff].minThr <= wVal[wred_regs_pkg::LO_MSB:0];
    end else if (wrStb && address == wred_regs_pkg::OFF_Q_PROB) begin
      qCfg_ff[qSel_ff].probMult <= wVal[wred_regs_pkg::HI_MSB:wred_regs_pkg::HI_LSB];
    end
  end

  // ==========================================================
  // monitor control bits
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      drop_ff <= '0;
      flushBit_ff <= 1'b0;
    end else if (wrStb && address == wred_regs_pkg::OFF_Q_MON) begin
      drop_ff.randomDropEn <= wVal[wred_regs_pkg::BIT_RAND_EN];
      flushBit_ff <= wVal[wred_regs_pkg::BIT_FLUSH];
      drop_ff.allColourDropInhibit <= wVal[wred_regs_pkg::BIT_ALL_INH];
      drop_ff.yellowRedDropInhibit <= wVal[wred_regs_pkg::BIT_YR_INH];
      drop_ff.redDropInhibit <= wVal[wred_regs_pkg::BIT_R_INH];
      drop_ff.dropAll <= wVal[wred_regs_pkg::BIT_DROP_ALL];
    end
  end

  // flush only when a write takes the bit from low to high
  assign flushEdge = wrStb && (address == wred_regs_pkg::OFF_Q_MON) &&
                     wVal[wred_regs_pkg::BIT_FLUSH] && !flushBit_ff;

  // event counters: flush clears all, then events count (flush wins same cycle)
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        evCnt_ff[i] <= wred_regs_pkg::CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        if (flushEdge) begin
          evCnt_ff[i] <= wred_regs_pkg::CNT_ZERO;
        end else if (queueEvent[i]) begin
          evCnt_ff[i] <= evCnt_ff[i] + wred_regs_pkg::CNT_ONE;
        end
      end
    end
  end

  // ==========================================================
  // queue index, vid replacement and police enable
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      qSel_ff <= 2'h0;
      vidRep_ff <= 1'b0;
      policeEn_ff <= 1'b0;
    end else if (wrStb && address == wred_regs_pkg::OFF_TXQ_SEL) begin
      qSel_ff <= wVal[1:0]; // byte lane 0 alone suffices
    end else if (wrStb && address == wred_regs_pkg::OFF_VID_REP) begin
      vidRep_ff <= wVal[0];
    end else if (wrStb && address == wred_regs_pkg::OFF_POLICE) begin
      policeEn_ff <= wVal[0];
    end
  end

  // ==========================================================
  // outputs to the datapath
  always_comb begin
    for (int i = 0; i < NUM_QUEUES; i++) begin
      queueCfg[i] = qCfg_ff[i];
    end
  end
  assign pmMaxThr = pmMax_ff;
  assign pmMinThr = pmMin_ff;
  assign pmProbMult = pmProb_ff;
  assign wredActive = policeEn_ff;
  // drop controls idle while policing and wred are off
  assign dropCtrl = policeEn_ff ? drop_ff : '0;
  assign vidReplaceEn = vidRep_ff;
  assign outerServiceTagSel = vidRep_ff && doubleTagEn;
endmodule

// ===== dv/port_wred_queue_regs_asserts.sv
// concurrent checks on the ports of the port wred register bank
`timescale 1ns/100ps
module port_wred_queue_regs_asserts #(
  parameter int NUM_QUEUES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register bus
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [1:0] response,
  // datapath side
  input wire wred_regs_pkg::queue_cfg_t [NUM_QUEUES-1:0] queueCfg,
  input wire logic [10:0] pmMaxThr,
  input wire logic [10:0] pmProbMult,
  input wire wred_regs_pkg::drop_ctrl_t dropCtrl,
  input wire logic wredActive,
  input wire logic vidReplaceEn,
  input wire logic outerServiceTagSel,
  input wire logic doubleTagEn
);
  // ==========================================================
  // one clock domain for every check
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // address hits one of the implemented registers
  logic mapped;
  assign mapped = address inside {12'h830, 12'h834, 12'h840, 12'h844, 12'h848, 12'h900,
    12'h904, 12'h80c};
  // request still waiting for its answer
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  a_one_wait: assert property (s_req |=> !waitrequest)
    else $error("answer not one cycle after request");
  a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
    else $error("wait raised without request");
  a_unmapped_resp: assert property (s_req && !mapped |=> response == 2'b10)
    else $error("unmapped access not refused");
  a_unmapped_zero: assert property (s_req && read && !mapped |=> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_mapped_ok: assert property (s_req && mapped |=> response == 2'b00)
    else $error("mapped access refused");
  a_reset_cfg: assert property ($rose(nrst) |-> pmMaxThr == 11'h400 && pmProbMult == 11'h020
    && queueCfg[0] == {11'h080, 11'h009, 11'h010}) else $error("config not at reset values");
  a_cfg_hold: assert property (!write |=> $stable(queueCfg) && $stable(pmMaxThr)
    && $stable(dropCtrl) && $stable(vidReplaceEn)) else $error("config moved without write");
  a_police_gate: assert property (!wredActive |-> dropCtrl == '0)
    else $error("drop controls live while police off");
  a_outer_tag: assert property (outerServiceTagSel == (vidReplaceEn && doubleTagEn))
    else $error("outer tag select wrong");
endmodule

// ===== dv/port_wred_queue_regs_tb.sv
// self-checking testbench of the port wred register bank
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module port_wred_queue_regs_tb;
  // ==========================================================
  // stimulus and observed signals
  logic ref_clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0, doubleTagEn = 1'b0;
  logic [11:0] address = 12'h0;
  logic [31:0] writedata = 32'h0, readdata, q, v, rs = 32'hf69d;
  logic [31:0] qt [4], qp [4];
  logic [3:0] byteenable = 4'hf, queueEvent = 4'h0;
  logic [1:0] response, r;
  logic [10:0] pmAvgSize = 11'h0, pmMaxThr, pmMinThr, pmProbMult;
  logic [43:0] queueAvgSize = 44'h0;
  logic waitrequest, wredActive, vidReplaceEn, outerServiceTagSel;
  wred_regs_pkg::queue_cfg_t [3:0] queueCfg;
  wred_regs_pkg::drop_ctrl_t dropCtrl;
  int miscompares = 0, compares = 0;
  // register map and reset images
  logic [11:0] adr [8] = '{12'h830, 12'h834, 12'h840, 12'h844, 12'h848, 12'h900, 12'h904, 12'h80c};
  logic [31:0] rst [8] = '{32'h04000080, 32'h00200000, 32'h00800009, 32'h00100000, 0, 0, 0, 0};
  always #50 ref_clk = ~ref_clk;
  port_wred_queue_regs #(.NUM_QUEUES(4)) dut (.ref_clk, .nrst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .response, .pmAvgSize, .queueAvgSize,
    .queueEvent, .queueCfg, .pmMaxThr, .pmMinThr, .pmProbMult, .dropCtrl, .wredActive,
    .vidReplaceEn, .outerServiceTagSel, .doubleTagEn);
  // xorshift source with fixed start
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // verdict and end of run
  task stop_test();
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle held until waitrequest is seen low
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      stop_test();
    end
    q = readdata;
    r = response;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
    bus(1'b1, a, d, be);
  endtask
  // event pulses on the chosen queues
  task pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      queueEvent <= m;
      @(posedge ref_clk);
    end
    queueEvent <= 4'h0;
    @(posedge ref_clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    pmAvgSize <= 11'(rnd());
    queueAvgSize <= {12'(rnd()), rnd()};
    for (int i = 0; i < 8; i++) begin
      rd(adr[i]);
      v = (i == 1) ? {21'h0, pmAvgSize} : (i == 3) ? {21'h0, queueAvgSize[10:0]} : 32'h0;
      `CHK("reset value", rst[i] | v, q)
    end
    wr(12'h830, 32'hffffffff);
    v = rnd();
    wr(12'h834, v);
    rd(12'h830);
    `CHK("pm thresholds", 32'h07ff07ff, q)
    rd(12'h834);
    `CHK("pm prob", {5'h0, v[26:16], 5'h0, pmAvgSize}, q)
    `CHK("pm outputs", {22'h3fffff, v[26:16]}, {pmMaxThr, pmMinThr, pmProbMult})
    // fill every queue, then read each back through the index
    for (int i = 0; i < 4; i++) begin
      wr(12'h900, 32'hffffff00 | i, 4'h1);
      qt[i] = rnd();
      qp[i] = rnd();
      wr(12'h840, qt[i]);
      wr(12'h844, qp[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(12'h900, i);
      rd(12'h900);
      `CHK("queue index", i, q)
      rd(12'h840);
      `CHK("queue thr", qt[i] & 32'h07ff07ff, q)
      rd(12'h844);
      `CHK("queue prob", {5'h0, qp[i][26:16], 5'h0, queueAvgSize[i*11+:11]}, q)
      `CHK("queue cfg", {qt[i][26:16], qt[i][10:0], qp[i][26:16]}, queueCfg[i])
    end
    // counter of queue two, flushed on a rising flush bit only
    wr(12'h900, 32'h2);
    pulse(4'h5, 3);
    pulse(4'h4, 2);
    rd(12'h848);
    `CHK("event count", 24'h5, q[23:0])
    wr(12'h848, 32'h40000000);
    rd(12'h848);
    `CHK("flushed count", 24'h0, q[23:0])
    pulse(4'h4, 3);
    wr(12'h848, 32'h40000000);
    rd(12'h848);
    `CHK("steady flush", 24'h3, q[23:0])
    // each drop control alone with police enabled, then gated off
    wr(12'h80c, 32'h1);
    `CHK("police on", 1'b1, wredActive)
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 32'h80000000 : 32'h40000000 >> k;
      wr(12'h848, v);
      rd(12'h848);
      `CHK("monitor ctl", v[31:24], q[31:24])
      `CHK("drop ctl", 5'h10 >> k, dropCtrl)
    end
    wr(12'h848, 32'hbc000000);
    wr(12'h80c, 32'h0);
    `CHK("police off", 6'h0, {wredActive, dropCtrl})
    // egress vid replacement with and without double tagging
    wr(12'h904, 32'hffffffff);
    rd(12'h904);
    `CHK("vid replace", 32'h1, q)
    doubleTagEn <= 1'b1;
    @(posedge ref_clk);
    `CHK("outer tag", 2'b11, {vidReplaceEn, outerServiceTagSel})
    wr(12'h904, 32'h0);
    `CHK("outer off", 2'b00, {vidReplaceEn, outerServiceTagSel})
    // unmapped place refuses both directions
    wr(12'h850, 32'hffffffff);
    `CHK("unmapped write", 2'b10, r)
    rd(12'h850);
    `CHK("unmapped read", 34'h200000000, {r, q})
    stop_test();
  end
endmodule
bind port_wred_queue_regs port_wred_queue_regs_asserts #(.NUM_QUEUES(NUM_QUEUES)) chk (
  .ref_clk, .nrst, .address, .read, .write, .readdata, .waitrequest, .response, .queueCfg,
  .pmMaxThr, .pmProbMult, .dropCtrl, .wredActive, .vidReplaceEn, .outerServiceTagSel,
  .doubleTagEn);
